// >>> verilog/acs_sequencer.sv
// acs_sequencer: 10-bit sar converter control sequencer with apb registers.
// assumes apb master on pclk, analog array answering cmp_above within a tick.
// Function
// (R01) zero acquisition: start converting without sampling
// (R02) software times acquisition when setting is zero
// (R03) nonzero setting: sample programmed periods, then convert
// (R04) completion clears busy, sets done, resumes sampling
// (R05) busy covers acquisition and conversion alike
// (R06) conversion lasts eleven bit periods
// (R07) clock select picks divisor or rc clock
// (R08) code 010 gives four period acquisition
// (R09) zero acquisition waits one instruction cycle
// (R10) clearing busy aborts conversion at once
// (R11) abort leaves result pair untouched
// (R12) two period wait, then sampling restarts
// (R13) software never enables and starts together
// (R14) compare event starts conversion, clears timer
// (R15) disabled converter ignores event, timer still clears
// (R16) calibration runs dummy conversion, stores offset
// (R17) software calibrates after reset and changes
// (R18) analog pins read zero on port
// (R19) software keeps divisor within frequency limit
// (R20) conversion start opens the holding switch
// (R21) acquisition codes give 0 to 20 periods
// (R22) justify bit picks right or left alignment
// (R23) reset turns converter off, aborts conversion
// (R24) one bit-period tick drives all counting; the instruction-cycle wait counts pclk cycles instead
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module acs_sequencer #(
  parameter int unsigned RC_DIV = acs_pkg::RC_DIV_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog array
  input wire logic cmp_above,
  output acs_pkg::acs_analog_s analog_o,
  // compare unit
  input wire logic special_event,
  output logic timer_clear,
  // port pins
  input wire logic [11:0] port_pin_in
);
  acs_pkg::acs_state_s r_reg;
  acs_pkg::acs_state_s r_next;

  logic tick;          // one bit period elapsed
  logic restart;       // realign the divider
  logic sar_clear;     // load msb trial
  logic sar_step;      // decide one bit
  logic [9:0] trial;   // sar code
  logic [9:0] corr;    // offset-corrected code
  logic [4:0] acq_len; // programmed acquisition in periods
  logic [11:0] analog_mask;
  logic [3:0] n_analog;
  logic acc_wr;
  logic acc_setup_rd;
  logic addr_ok;
  logic abort_req;

  // bit-period source shared by the acquisition, conversion and recovery counters (see R24)
  acs_tad_divider #(.RC_DIV(RC_DIV)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .clk_sel(r_reg.clk_sel),
    .tick(tick)
  );

  // successive-approximation register
  acs_sar u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .clear(sar_clear),
    .step(sar_step),
    .cmp_above(cmp_above),
    .trial(trial)
  );

  // acquisition length from the code table (see R08) (see R21)
  assign acq_len = acs_pkg::ACQ_TADS[r_reg.acq_sel];
  // subtract stored offset, floor at zero (see R16)
  assign corr = (trial >= r_reg.offset) ? (trial - r_reg.offset) : 10'h000;

  // analog count from pin configuration
  assign n_analog = (r_reg.pcfg <= acs_pkg::PCFG_ALL_ANALOG_MAX) ?
                    4'hc : (acs_pkg::PCFG_TOP - r_reg.pcfg);

  // one analog mask bit per pin
  genvar gi;
  generate
    for (gi = 0; gi < acs_pkg::NUM_CHAN; gi++) begin : g_mask
      assign analog_mask[gi] = (4'(gi) < n_analog);
    end
  endgenerate

  // apb decode; zero wait states, so access always completes
  assign acc_wr = psel && penable && pwrite;
  assign acc_setup_rd = psel && !penable && !pwrite;
  assign addr_ok = (paddr == acs_pkg::OFF_CTRL0) || (paddr == acs_pkg::OFF_CTRL1) ||
                   (paddr == acs_pkg::OFF_STATUS) || (paddr == acs_pkg::OFF_RESULT) ||
                   (paddr == acs_pkg::OFF_PORT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = r_reg.prdata;
  assign timer_clear = r_reg.timer_clear;
  // write that clears busy with enable kept set; whether busy is set is checked where it is used
  assign abort_req = acc_wr && addr_ok && (paddr == acs_pkg::OFF_CTRL0) &&
                     pwdata[acs_pkg::F_ENABLE] && !pwdata[acs_pkg::F_BUSY];

  // analog drive from registered state
  always_comb begin
    analog_o.channel = r_reg.chan;
    analog_o.cal_mode = r_reg.cal_run;
    analog_o.trial = trial;
    // switch closed only while sampling; opened for conversion (see R20) (see R01)
    analog_o.hold_connect = ((r_reg.st == acs_pkg::ST_SAMPLE) || (r_reg.st == acs_pkg::ST_ACQ))
                            && !r_reg.cal_run;
  end

  // next state: simple writes, sequencer, then control write and trigger
  always_comb begin
    r_next = r_reg;
    restart = 1'b0;
    sar_clear = 1'b0;
    sar_step = 1'b0;
    r_next.timer_clear = 1'b0;

    // read data captured in setup so prdata comes from a flop
    if (acc_setup_rd) begin
      unique case (paddr)
        acs_pkg::OFF_CTRL0: r_next.prdata = {24'h000000, r_reg.cal_req, 1'b0, r_reg.chan,
                                             r_reg.busy, r_reg.enable};
        acs_pkg::OFF_CTRL1: r_next.prdata = {16'h0000, r_reg.pcfg, r_reg.ccp_mode,
                                             r_reg.justify, 1'b0, r_reg.acq_sel,
                                             r_reg.clk_sel};
        acs_pkg::OFF_STATUS: r_next.prdata = {31'h00000000, r_reg.done_flag};
        acs_pkg::OFF_RESULT: r_next.prdata = {16'h0000, r_reg.result};
        // analog pins read as zero (see R18)
        acs_pkg::OFF_PORT: r_next.prdata = {20'h00000, port_pin_in & ~analog_mask};
        default: r_next.prdata = 32'h00000000;
      endcase
    end

    // writes that cannot collide with sequencer updates of the same field
    if (acc_wr && (paddr == acs_pkg::OFF_CTRL1)) begin
      r_next.clk_sel = pwdata[acs_pkg::F_CLKSEL_LO +: 3];
      r_next.acq_sel = pwdata[acs_pkg::F_ACQ_LO +: 3];
      r_next.justify = pwdata[acs_pkg::F_JUSTIFY];
      r_next.ccp_mode = pwdata[acs_pkg::F_CCPMODE_LO +: 4];
      r_next.pcfg = pwdata[acs_pkg::F_PCFG_LO +: 4];
    end
    // done flag clear first, so a completion in the same cycle still sets it
    if (acc_wr && (paddr == acs_pkg::OFF_STATUS) && pwdata[acs_pkg::F_DONE]) begin
      r_next.done_flag = 1'b0;
    end
    // software may load the result pair; a completion below wins
    if (acc_wr && (paddr == acs_pkg::OFF_RESULT)) begin
      r_next.result = pwdata[15:0];
    end

    // sequencer; busy stays set from start to finish with no phase status (see R05)
    unique case (r_reg.st)
      acs_pkg::ST_OFF: begin
        r_next.cnt = 5'h00;
      end
      acs_pkg::ST_SAMPLE: begin
        // start request waiting
        if (r_reg.busy) begin
          r_next.cal_run = r_reg.cal_req; // dummy conversion on this start (see R16)
          r_next.cnt = 5'h00;
          if (r_reg.acq_sel == 3'b000) begin
            r_next.st = acs_pkg::ST_WAIT_INSTR; // (see R01)
            r_next.icnt = 3'h0;
          end else begin
            r_next.st = acs_pkg::ST_ACQ; // (see R03)
            restart = 1'b1;
          end
        end
      end
      acs_pkg::ST_WAIT_INSTR: begin
        // one instruction cycle lets a sleep execute first (see R09)
        r_next.icnt = r_reg.icnt + 3'h1;
        if (r_reg.icnt == 3'(acs_pkg::INSTR_CYCLES - 1)) begin
          r_next.st = acs_pkg::ST_CONV;
          r_next.cnt = 5'h00;
          restart = 1'b1;
          sar_clear = 1'b1;
        end
      end
      acs_pkg::ST_ACQ: begin
        // keep sampling the programmed number of periods (see R03) (see R08)
        if (tick) begin
          r_next.cnt = r_reg.cnt + 5'h01;
          if (r_reg.cnt == acq_len - 5'h01) begin
            r_next.st = acs_pkg::ST_CONV;
            r_next.cnt = 5'h00;
            sar_clear = 1'b1;
          end
        end
      end
      acs_pkg::ST_CONV: begin
        // ten decisions then one closing period: eleven in all (see R06)
        if (tick) begin
          r_next.cnt = r_reg.cnt + 5'h01;
          if (r_reg.cnt == acs_pkg::CONV_TADS - 5'h01) begin
            r_next.busy = 1'b0;     // (see R04)
            r_next.done_flag = 1'b1;
            r_next.st = acs_pkg::ST_RECOVER;
            r_next.cnt = 5'h00;
            if (r_reg.cal_run) begin
              // offset kept internally, result pair untouched (see R16)
              r_next.offset = trial;
              r_next.cal_req = 1'b0;
              r_next.cal_run = 1'b0;
            end else if (r_reg.justify) begin
              r_next.result = {6'h00, corr}; // right aligned (see R22)
            end else begin
              r_next.result = {corr, 6'h00}; // left aligned (see R22)
            end
          end else begin
            sar_step = 1'b1;
          end
        end
      end
      acs_pkg::ST_RECOVER: begin
        // idle wait before sampling may restart (see R12)
        if (tick) begin
          r_next.cnt = r_reg.cnt + 5'h01;
          if (r_reg.cnt == acs_pkg::RECOVER_TADS - 5'h01) begin
            r_next.st = acs_pkg::ST_SAMPLE; // (see R04)
            r_next.cnt = 5'h00;
          end
        end
      end
      default: begin
        r_next.st = acs_pkg::ST_OFF;
      end
    endcase

    // control write
    if (acc_wr && (paddr == acs_pkg::OFF_CTRL0)) begin
      r_next.chan = pwdata[acs_pkg::F_CHAN_LO +: 4];
      r_next.cal_req = pwdata[acs_pkg::F_CAL];
      r_next.enable = pwdata[acs_pkg::F_ENABLE];
      if (!pwdata[acs_pkg::F_ENABLE]) begin
        // disable drops any sequence in flight
        r_next.busy = 1'b0;
        r_next.cal_run = 1'b0;
        r_next.st = acs_pkg::ST_OFF;
      end else if (!r_reg.enable) begin
        // a start in the enabling write is dropped (see R13)
        r_next.busy = 1'b0;
        r_next.st = acs_pkg::ST_SAMPLE;
      end else if (pwdata[acs_pkg::F_BUSY] && !r_reg.busy) begin
        r_next.busy = 1'b1;
      end else if (abort_req && r_next.busy) begin
        // abort immediately; no result update (see R10) (see R11)
        r_next.busy = 1'b0;
        r_next.cal_run = 1'b0;
        if (r_reg.st != acs_pkg::ST_SAMPLE) begin
          r_next.st = acs_pkg::ST_RECOVER; // (see R12)
          r_next.cnt = 5'h00;
          restart = 1'b1;
        end
      end
    end

    // compare unit special event
    if (special_event && (r_reg.ccp_mode == acs_pkg::CCP_TRIGGER_MODE)) begin
      r_next.timer_clear = 1'b1;  // timer cleared either way (see R14) (see R15)
      if (r_reg.enable && r_next.enable) begin
        r_next.busy = 1'b1;       // (see R14)
      end
    end
  end

  // state register; reset leaves converter off and idle (see R23)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{st: acs_pkg::ST_OFF, result: acs_pkg::RESULT_RESET,
                 offset: acs_pkg::OFFSET_RESET, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // completion drops busy and raises done
  chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn) // see R04
    (r_reg.st == acs_pkg::ST_CONV && tick && r_reg.cnt == 5'h0a && r_reg.enable &&
     !(acc_wr && paddr == acs_pkg::OFF_CTRL0 && !pwdata[acs_pkg::F_ENABLE]) &&
     !(special_event && r_reg.ccp_mode == acs_pkg::CCP_TRIGGER_MODE))
    |=> (!r_reg.busy && r_reg.done_flag && r_reg.st == acs_pkg::ST_RECOVER))
    else $error("completion did not clear busy and set done");

  // abort keeps the result pair
  chk_abort_keep: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (r_reg.st == acs_pkg::ST_CONV && abort_req && !(tick && r_reg.cnt == 5'h0a))
    |=> (r_reg.result == $past(r_reg.result) && r_reg.st == acs_pkg::ST_RECOVER))
    else $error("abort changed result or kept converting");

  // holding switch open during conversion
  chk_hold_open: assert property (@(posedge pclk) disable iff (!presetn) // see R20
    (r_reg.st == acs_pkg::ST_CONV) |-> !analog_o.hold_connect)
    else $error("holding switch closed during conversion");

  // recovery ends after the second tick
  chk_recover_end: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    (r_reg.st == acs_pkg::ST_RECOVER && tick && r_reg.cnt == 5'h01 && r_reg.enable &&
     !(acc_wr && paddr == acs_pkg::OFF_CTRL0))
    |=> (r_reg.st == acs_pkg::ST_SAMPLE))
    else $error("recovery did not end after two periods");

  // zero acquisition converts after one instruction cycle
  chk_zero_acq: assert property (@(posedge pclk) disable iff (!presetn) // see R09
    (r_reg.st == acs_pkg::ST_SAMPLE && r_reg.busy && r_reg.acq_sel == 3'b000 && r_reg.enable
     && !(acc_wr && paddr == acs_pkg::OFF_CTRL0))
    |=> (r_reg.st == acs_pkg::ST_WAIT_INSTR) [*4] ##1 (r_reg.st == acs_pkg::ST_CONV))
    else $error("zero acquisition start not one instruction late");

  // acquisition ends on the programmed count
  chk_acq_count: assert property (@(posedge pclk) disable iff (!presetn) // see R03
    (r_reg.st == acs_pkg::ST_ACQ && tick && r_reg.cnt == acq_len - 5'h01 && r_reg.enable &&
     !abort_req && !(acc_wr && paddr == acs_pkg::OFF_CTRL0))
    |=> (r_reg.st == acs_pkg::ST_CONV && r_reg.cnt == 5'h00))
    else $error("acquisition length wrong");

  // event starts the converter when enabled
  chk_ext_trigger: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    (special_event && r_reg.ccp_mode == acs_pkg::CCP_TRIGGER_MODE && r_reg.enable &&
     !(acc_wr && paddr == acs_pkg::OFF_CTRL0))
    |=> (r_reg.busy && timer_clear))
    else $error("special event did not start conversion");

  // event ignored when disabled, timer still cleared
  chk_trig_ignore: assert property (@(posedge pclk) disable iff (!presetn) // see R15
    (special_event && r_reg.ccp_mode == acs_pkg::CCP_TRIGGER_MODE && !r_reg.enable &&
     !(acc_wr && paddr == acs_pkg::OFF_CTRL0))
    |=> (!r_reg.busy && timer_clear))
    else $error("disabled converter reacted to special event");

  // conversion count never passes eleven periods
  chk_conv_len: assert property (@(posedge pclk) disable iff (!presetn) // see R06
    (r_reg.st == acs_pkg::ST_CONV) |-> (r_reg.cnt <= 5'h0a))
    else $error("conversion ran past eleven periods");
endmodule // acs_sequencer

// >>> verilog/acs_pkg.sv
// acs_pkg: shared constants, types and register map of the conversion sequencer.
// assumes a 200 MHz pclk; all times are turned into pclk cycles here.
package acs_pkg;

  // bus and clock timing
  localparam int unsigned CLK_PERIOD_PS = 5000;    // pclk period
  localparam int unsigned RC_TAD_PS = 4000000;     // internal rc bit period, typical 4 us
  localparam int unsigned RC_DIV_CYCLES = RC_TAD_PS / CLK_PERIOD_PS;
  localparam int unsigned INSTR_TOSC = 4;          // one instruction cycle in oscillator periods
  localparam int unsigned INSTR_CYCLES = INSTR_TOSC;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;       // enable, start/busy, channel, calibrate
  localparam logic [7:0] OFF_CTRL1 = 8'h04;       // clock, acquisition, justify, trigger, pins
  localparam logic [7:0] OFF_STATUS = 8'h08;      // done flag, write one to clear
  localparam logic [7:0] OFF_RESULT = 8'h0c;      // result pair, high byte in [15:8]
  localparam logic [7:0] OFF_PORT = 8'h10;        // port pin read-back

  // ctrl0 fields
  localparam int unsigned F_ENABLE = 0;
  localparam int unsigned F_BUSY = 1;
  localparam int unsigned F_CHAN_LO = 2;
  localparam int unsigned F_CAL = 7;
  // ctrl1 fields
  localparam int unsigned F_CLKSEL_LO = 0;
  localparam int unsigned F_ACQ_LO = 3;
  localparam int unsigned F_JUSTIFY = 7;
  localparam int unsigned F_CCPMODE_LO = 8;
  localparam int unsigned F_PCFG_LO = 12;
  // status fields
  localparam int unsigned F_DONE = 0;

  // reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [9:0] OFFSET_RESET = 10'h000;

  // sequencing counts, in bit periods
  localparam logic [4:0] CONV_TADS = 5'h0b;       // 11 periods per 10-bit conversion
  localparam logic [4:0] RECOVER_TADS = 5'h02;    // wait after completion or abort
  localparam logic [4:0] ACQ_TADS [8] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                          5'h08, 5'h0c, 5'h10, 5'h14};
  localparam logic [3:0] CCP_TRIGGER_MODE = 4'hb; // compare unit special event mode
  localparam logic [3:0] PCFG_ALL_ANALOG_MAX = 4'h3;
  localparam logic [3:0] PCFG_TOP = 4'hf;
  localparam int unsigned NUM_CHAN = 12;

  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_WAIT_INSTR, ST_ACQ, ST_CONV, ST_RECOVER
  } acs_phase_e;

  // everything the sequencer remembers
  typedef struct packed {
    acs_phase_e st;
    logic enable;
    logic busy;
    logic [3:0] chan;
    logic cal_req;
    logic cal_run;
    logic [2:0] clk_sel;
    logic [2:0] acq_sel;
    logic justify;
    logic [3:0] ccp_mode;
    logic [3:0] pcfg;
    logic done_flag;
    logic [15:0] result;
    logic [9:0] offset;
    logic [4:0] cnt;
    logic [2:0] icnt;
    logic timer_clear;
    logic [31:0] prdata;
  } acs_state_s;

  // drive toward the analog sample/hold and array
  typedef struct packed {
    logic hold_connect;   // sampling switch closed
    logic cal_mode;       // no input channel routed
    logic [3:0] channel;
    logic [9:0] trial;    // present successive-approximation code
  } acs_analog_s;

endpackage

// >>> verilog/acs_tad_divider.sv
// acs_tad_divider: makes the one-cycle bit-period tick from pclk.
// assumes the rc oscillator is modelled as a fixed pclk divide.
`timescale 1ns/1ps
module acs_tad_divider #(
  parameter int unsigned RC_DIV = acs_pkg::RC_DIV_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic [2:0] clk_sel,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [9:0] cnt;
  } acs_div_s;

  acs_div_s r_reg;
  acs_div_s r_next;
  logic [9:0] lim;   // last count of one period
  logic [2:0] expo;  // divisor is two to this power

  // code to divisor: 000/100/001/101/010/110 give 2..64, x11 the rc clock (see R07)
  always_comb begin
    expo = 3'({clk_sel[1:0], 1'b0}) + 3'(clk_sel[2]) + 3'h1;
    if (clk_sel[1:0] == 2'b11) begin
      lim = 10'(RC_DIV - 1);
    end else begin
      lim = 10'((32'h1 << expo) - 32'h1);
    end
    tick = (r_reg.cnt == lim) && !restart;
    r_next = r_reg;
    // restart aligns a whole period to the start of a phase (see R24)
    if (restart || tick) begin
      r_next.cnt = 10'h000;
    end else begin
      r_next.cnt = r_reg.cnt + 10'h001;
    end
  end

  // count register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // acs_tad_divider

// >>> verilog/acs_sar.sv
// acs_sar: successive-approximation code register, msb first.
// assumes cmp_above is settled by the time step is pulsed.
`timescale 1ns/1ps
module acs_sar (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clear,
  input wire logic step,
  input wire logic cmp_above,
  // code out
  output logic [9:0] trial
);
  typedef struct packed {
    logic [9:0] trial;
    logic [9:0] mask;
  } acs_sar_s;

  acs_sar_s r_reg;
  acs_sar_s r_next;
  logic [9:0] nm; // next bit under trial

  // keep the bit when the held level is above the trial code
  always_comb begin
    r_next = r_reg;
    nm = r_reg.mask >> 1;
    if (clear) begin
      r_next.trial = 10'h200;
      r_next.mask = 10'h200;
    end else if (step) begin
      r_next.trial = (cmp_above ? r_reg.trial : (r_reg.trial & ~r_reg.mask)) | nm;
      r_next.mask = nm;
    end
  end

  assign trial = r_reg.trial;

  // code register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // acs_sar

// >>> bench/acs_analog_model.sv
// acs_analog_model: holding capacitor and comparator behind the sequencer.
// assumes the bench drives the pin level; dummy runs see a fixed offset.
`timescale 1ns/1ps
module acs_analog_model #(
  parameter logic [9:0] CAL_LEVEL = 10'h007 // offset seen with no channel routed
) (
  // clock
  input wire logic pclk,
  // from sequencer
  input wire acs_pkg::acs_analog_s analog_o,
  // pin level
  input wire logic [9:0] vin,
  // comparator
  output logic cmp_above
);
  logic [9:0] held_reg = 10'h000; // charge on the holding capacitor
  // capacitor follows the pin only while the switch is closed
  always @(posedge pclk) begin
    if (analog_o.cal_mode) begin
      held_reg <= CAL_LEVEL; // dummy run reads no pin
    end else if (analog_o.hold_connect) begin
      held_reg <= vin; // an open switch freezes the level
    end
  end
  // bit is kept while the held level is not below the trial code
  assign cmp_above = (held_reg >= analog_o.trial);
endmodule // acs_analog_model

// >>> bench/acs_sequencer_test.sv
// acs_sequencer_test: apb-driven checks of the conversion sequencer.
// assumes acs_analog_model on the far side and pclk at 200 MHz.
`timescale 1ns/1ps
module acs_sequencer_test;
  localparam int RC = 4; // short rc bit period keeps the run brief
  // bench signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, cmp_above, timer_clear, err;
  logic special_event = 1'b0;
  logic [11:0] port_pin_in = 12'ha5c;
  logic [9:0] vin = 10'h1c3, ev;
  acs_pkg::acs_analog_s analog_o;
  int n_mismatch = 0, total_checks = 0, cyc = 0, c1, c2;
  logic [2:0] cs [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int dv [8] = '{2, 4, 8, 16, 32, 64, RC, RC};
  always #2.5 pclk = ~pclk;
  acs_sequencer #(.RC_DIV(RC)) u_acs_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above), .analog_o(analog_o),
    .special_event(special_event), .timer_clear(timer_clear), .port_pin_in(port_pin_in));
  acs_analog_model u_acs_analog_model (.pclk(pclk), .analog_o(analog_o), .vin(vin),
    .cmp_above(cmp_above));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // counts may fall two cycles short or run four long with divider phase
  task automatic rng(input int v, input int lo);
    chk(32'(v + 2 >= lo && v <= lo + 4), 32'h1);
  endtask
  // one apb transfer; an edge first so no strobe toggles twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count sampling edges, then switch-open edges; pin moves once held
  task automatic track();
    c1 = 0;
    c2 = 0;
    ev = vin;
    while (analog_o.hold_connect !== 1'b0) begin
      @(posedge pclk);
      c1++;
    end
    vin <= ~vin;
    while (analog_o.hold_connect !== 1'b1) begin
      @(posedge pclk);
      c2++;
    end
  endtask
  // compare-unit event pulse, timer clear looked at one edge later
  task automatic evt();
    @(posedge pclk);
    special_event <= 1'b1;
    @(posedge pclk);
    special_event <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard well above the expected few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acs_pkg::OFF_RESULT, 32'h0);
    chk(q, 32'(acs_pkg::RESULT_RESET));
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h1); // enable alone first
    for (int a = 0; a < 8; a++) begin
      apb(1'b1, acs_pkg::OFF_CTRL1, 32'h80 | 32'(a << 3));
      apb(1'b1, acs_pkg::OFF_CTRL0, 32'h3); // pin settled long before
      track();
      rng(c1 + c2, 26 + (a == 0 ? acs_pkg::INSTR_CYCLES : 2 * int'(acs_pkg::ACQ_TADS[a])));
      if (a != 0) rng(c2, 26);
      apb(1'b0, acs_pkg::OFF_RESULT, 32'h0);
      chk(q, {22'h0, ev});
    end
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, acs_pkg::OFF_STATUS, 32'h1);
    apb(1'b0, acs_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h0);
    $display("test acquisition done");
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, acs_pkg::OFF_CTRL1, 32'h88 | 32'(cs[k])); // divisor picked by software
      apb(1'b1, acs_pkg::OFF_CTRL0, 32'h3);
      track();
      rng(c1, 2 * dv[k]);
      rng(c2, 13 * dv[k]);
    end
    $display("test clock select done");
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'h8e);
    apb(1'b1, acs_pkg::OFF_RESULT, 32'h155);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h3);
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk(q[1], 1'b1); // busy through acquisition
    repeat (200) @(posedge pclk);
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk({q[1], analog_o.hold_connect}, 2'b10);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h1); // abort
    track();
    rng(c2, 128);
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk(q[1], 1'b0);
    apb(1'b0, acs_pkg::OFF_RESULT, 32'h0);
    chk(q, 32'h155);
    $display("test abort done");
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(err), 32'h1);
    chk(q, 32'h0);
    for (int p = 0; p < 16; p++) begin
      apb(1'b1, acs_pkg::OFF_CTRL1, 32'(p << 12));
      apb(1'b0, acs_pkg::OFF_PORT, 32'h0);
      chk(q, p < 4 ? 32'h0 : 32'ha5c & ~((32'h1 << (15 - p)) - 32'h1));
    end
    $display("test port done");
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'h080);
    evt();
    chk(timer_clear, 1'b0);
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'hb80);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h0);
    evt();
    chk(timer_clear, 1'b1);
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk(q[1], 1'b0);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h1);
    evt();
    chk(timer_clear, 1'b1);
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk(q[1], 1'b1);
    track();
    $display("test trigger done");
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h81); // calibrate after reset
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h83);
    track();
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h29);
    @(posedge pclk);
    chk(32'(analog_o.channel), 32'ha);
    apb(1'b1, acs_pkg::OFF_CTRL1, 32'h000);
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h3);
    track();
    apb(1'b0, acs_pkg::OFF_RESULT, 32'h0);
    chk(q, 32'({ev - 10'h007, 6'h00}));
    apb(1'b1, acs_pkg::OFF_CTRL0, 32'h3);
    repeat (10) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, acs_pkg::OFF_CTRL0, 32'h0);
    chk(q, 32'h0);
    chk(32'(analog_o.hold_connect), 32'h0);
    $display("test calibrate and reset done");
    test_done();
  end
endmodule // acs_sequencer_test
